// *** cmu_top.sv ***
`include "cmu_cfg.svh"
module cmu_top
    import cmu_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       ce,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] pwm_base,
    input  wire logic [1:0] pwm_frac,
    input  wire logic       pwm_period,
    input  wire logic       port_g_line3_in,
    input  wire logic       port_g_line4_in,
    output logic [7:0]      rdata_q,
    output logic            port_g_line3_q,
    output logic            port_g_line4_q,
    output logic            unit4_open_drain_q,
    output logic            unit5_open_drain_q,
    output logic            special_event_q,
    output logic            irq_q
);
    logic [15:0] t1_q;
    logic [15:0] t3_q;
    logic [7:0]  first_timer_control_q;
    logic [7:0]  third_timer_control_q;
    logic [7:0]  odsel_q;
    logic [7:0]  wdcon_q;
    logic [15:0] val_q   [2];
    cmu_ctrl_t   ctrl_q  [2];
    logic [1:0]  status_q;
    logic [1:0]  mask_q;
    logic [2:0]  s4_q;
    logic [2:0]  s5_q;
    logic [1:0]  pin_in;
    logic [1:0]  pin;
    logic [1:0]  ctrl_wr;
    logic [1:0]  ctrl_wr_q;
    logic [1:0]  flt_q;
    logic [15:0] tb     [2];
    cmu_evt_t    evt    [2];
    logic [15:0] capt   [2];
    logic        share;

    // Timer assignment: low bit picks third for unit 4, high for unit 5
    always_comb
    begin
        tb[0] = third_timer_control_q[`CMU_T3_ASGN_LO] ? t3_q : t1_q;
        tb[1] = third_timer_control_q[`CMU_T3_ASGN_HI] ? t3_q : t1_q;
    end

    assign share = wdcon_q[`CMU_WD_SHARE];
    assign ctrl_wr[0] = wr && addr == `CMU_A_U4CON;
    assign ctrl_wr[1] = wr && addr == `CMU_A_U5CON;

    // Pin input synchronisers, stage 2 and 3 compared
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s4_q  <= 3'h0;
            s5_q  <= 3'h0;
            flt_q <= 2'h0;
        end
        else if (ce)
        begin
            s4_q  <= {s4_q[1:0], port_g_line3_in};
            s5_q  <= {s5_q[1:0], port_g_line4_in};
            flt_q <= pin_in;
        end
    end
    // Level moves only when stages 2 and 3 agree
    assign pin_in[0] = (s4_q[1] == s4_q[2]) ? s4_q[2] : flt_q[0];
    assign pin_in[1] = (s5_q[1] == s5_q[2]) ? s5_q[2] : flt_q[1];

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_unit
            cmu_unit #(.WIDTH(16)) u_unit (
                .clk         (clk),
                .reset       (reset),
                .ce          (ce),
                .ctrl        (ctrl_q[g]),
                .ctrl_wr     (ctrl_wr_q[g]),
                .match_value (val_q[g]),
                .time_base   (tb[g]),
                .pwm_base    (pwm_base),
                .pwm_frac    (pwm_frac),
                .pwm_period  (pwm_period),
                .pin_in      (pin_in[g]),
                .pin_q       (pin[g]),
                .evt_q       (evt[g]),
                .capt_q      (capt[g])
            );
        end
    endgenerate

    // Timer counts, controls, watchdog and shared open-drain
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            t1_q    <= '0;
            t3_q    <= '0;
            first_timer_control_q <= `CMU_RST_BYTE;
            third_timer_control_q <= `CMU_RST_BYTE;
            odsel_q <= `CMU_RST_BYTE;
            wdcon_q <= `CMU_RST_BYTE;
        end
        else if (ce && wr)
        begin
            unique case (addr)
                `CMU_A_T1L:   t1_q[7:0] <= wdata;
                `CMU_A_T1H:
                    if (share)
                        odsel_q <= {3'h0, wdata[4:0]};
                    else
                        t1_q[15:8] <= wdata;
                `CMU_A_FIRST_TIMER_CONTROL: first_timer_control_q <= wdata;
                `CMU_A_T3L:   t3_q[7:0] <= wdata;
                `CMU_A_T3H:   t3_q[15:8] <= wdata;
                `CMU_A_THIRD_TIMER_CONTROL: third_timer_control_q <= wdata;
                `CMU_A_WDCON: wdcon_q <= wdata;
                default: ;
            endcase
        end
    end

    // Unit value and control registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            val_q[0]  <= `CMU_RST_VALUE;
            val_q[1]  <= `CMU_RST_VALUE;
            ctrl_q[0] <= `CMU_RST_BYTE;
            ctrl_q[1] <= `CMU_RST_BYTE;
            ctrl_wr_q <= 2'h0;
        end
        else if (ce)
        begin
            // Delayed so the unit sees the new mode with the strobe
            ctrl_wr_q <= ctrl_wr;
            if (evt[0].capture)
                val_q[0] <= capt[0];
            if (evt[1].capture)
                val_q[1] <= capt[1];
            if (wr)
            begin
                unique case (addr)
                    `CMU_A_U4L:   val_q[0][7:0]  <= wdata;
                    `CMU_A_U4H:   val_q[0][15:8] <= wdata;
                    `CMU_A_U5L:   val_q[1][7:0]  <= wdata;
                    `CMU_A_U5H:   val_q[1][15:8] <= wdata;
                    `CMU_A_U4CON: ctrl_q[0] <= {2'b00, wdata[5:0]};
                    `CMU_A_U5CON: ctrl_q[1] <= {2'b00, wdata[5:0]};
                    default: ;
                endcase
            end
        end
    end

    // Sticky match and capture flags, set wins over write-one clear
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            status_q <= 2'h0;
            mask_q   <= 2'h0;
        end
        else if (ce)
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (evt[i].match || evt[i].capture)
                    status_q[i] <= 1'b1;
                else if (wr && addr == `CMU_A_STATUS && wdata[i])
                    status_q[i] <= 1'b0;
            end
            if (wr && addr == `CMU_A_MASK)
                mask_q <= wdata[1:0];
        end
    end

    // Outputs straight from flops
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            port_g_line3_q     <= 1'b0;
            port_g_line4_q     <= 1'b0;
            unit4_open_drain_q <= 1'b0;
            unit5_open_drain_q <= 1'b0;
            special_event_q    <= 1'b0;
            irq_q              <= 1'b0;
        end
        else if (ce)
        begin
            port_g_line3_q     <= pin[0];
            port_g_line4_q     <= pin[1];
            unit4_open_drain_q <= odsel_q[3];
            unit5_open_drain_q <= odsel_q[4];
            special_event_q    <= evt[0].special || evt[1].special;
            irq_q <= |(status_q & mask_q);
        end
    end

    // Read port, data in the cycle after the strobe
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            rdata_q <= 8'h00;
        else if (ce)
        begin
            rdata_q <= 8'h00;
            if (rd)
            begin
                unique case (addr)
                    `CMU_A_T1L:   rdata_q <= t1_q[7:0];
                    `CMU_A_T1H:   rdata_q <= share ? odsel_q : t1_q[15:8];
                    `CMU_A_FIRST_TIMER_CONTROL: rdata_q <= first_timer_control_q;
                    `CMU_A_T3L:   rdata_q <= t3_q[7:0];
                    `CMU_A_T3H:   rdata_q <= t3_q[15:8];
                    `CMU_A_THIRD_TIMER_CONTROL: rdata_q <= third_timer_control_q;
                    `CMU_A_U4L:   rdata_q <= val_q[0][7:0];
                    `CMU_A_U4H:   rdata_q <= val_q[0][15:8];
                    `CMU_A_U5L:   rdata_q <= val_q[1][7:0];
                    `CMU_A_U5H:   rdata_q <= val_q[1][15:8];
                    `CMU_A_U4CON: rdata_q <= ctrl_q[0];
                    `CMU_A_U5CON: rdata_q <= ctrl_q[1];
                    `CMU_A_WDCON: rdata_q <= wdcon_q;
                    `CMU_A_STATUS: rdata_q <= {6'h00, status_q};
                    `CMU_A_MASK:  rdata_q <= {6'h00, mask_q};
                    default:      rdata_q <= 8'h00;
                endcase
            end
        end
    end
endmodule

// *** cmu_cfg.svh ***
`ifndef CMU_CFG_SVH
`define CMU_CFG_SVH
// Register map: 8-bit index on the plain port
`define CMU_A_T1L      8'h00
`define CMU_A_T1H      8'h01
`define CMU_A_FIRST_TIMER_CONTROL    8'h02
`define CMU_A_T3L      8'h03
`define CMU_A_T3H      8'h04
`define CMU_A_THIRD_TIMER_CONTROL    8'h05
`define CMU_A_U4L      8'h06
`define CMU_A_U4H      8'h07
`define CMU_A_U5L      8'h08
`define CMU_A_U5H      8'h09
`define CMU_A_U4CON    8'h0A
`define CMU_A_U5CON    8'h0B
`define CMU_A_WDCON    8'h0C
`define CMU_A_STATUS   8'h0D
`define CMU_A_MASK     8'h0E
// Field positions
`define CMU_WD_SHARE   4
`define CMU_T3_ASGN_LO 3
`define CMU_T3_ASGN_HI 6
`define CMU_ST_U4      0
`define CMU_ST_U5      1
// Reset values
`define CMU_RST_BYTE   8'h00
`define CMU_RST_VALUE  16'hFFFF
`endif

// *** cmu_pkg.sv ***
package cmu_pkg;
    // Mode select encodings
    typedef enum logic [3:0] {
        CMU_OFF     = 4'h0,
        CMU_RSV1    = 4'h1,
        CMU_TOGGLE  = 4'h2,
        CMU_RSV3    = 4'h3,
        CMU_CAP_FALL = 4'h4,
        CMU_CAP_RISE = 4'h5,
        CMU_CAP_4   = 4'h6,
        CMU_CAP_16  = 4'h7,
        CMU_SET_HI  = 4'h8,
        CMU_SET_LO  = 4'h9,
        CMU_SW_IRQ  = 4'hA,
        CMU_SPECIAL = 4'hB,
        CMU_PWM0    = 4'hC,
        CMU_PWM1    = 4'hD,
        CMU_PWM2    = 4'hE,
        CMU_PWM3    = 4'hF
    } cmu_mode_t;

    // Unit control byte
    typedef struct packed {
        logic [1:0] unused;
        logic [1:0] duty_low_bits;
        cmu_mode_t  mode_select;
    } cmu_ctrl_t;

    // Unit output events
    typedef struct packed {
        logic match;
        logic special;
        logic capture;
    } cmu_evt_t;
endpackage

// *** cmu_unit.sv ***
`include "cmu_cfg.svh"
// One compare/capture/pwm unit
module cmu_unit
    import cmu_pkg::*;
#(
    parameter int WIDTH = 16
)(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire cmu_ctrl_t        ctrl,
    input  wire logic             ctrl_wr,
    input  wire logic [WIDTH-1:0] match_value,
    input  wire logic [WIDTH-1:0] time_base,
    input  wire logic [7:0]       pwm_base,
    input  wire logic [1:0]       pwm_frac,
    input  wire logic             pwm_period,
    input  wire logic             pin_in,
    output logic                  pin_q,
    output cmu_evt_t              evt_q,
    output logic [WIDTH-1:0]      capt_q
);
    // Only a 16-bit time base is served
    generate
        if (WIDTH != 16)
        begin : g_bad_width
            $error("cmu_unit supports a 16-bit time base only");
        end
    endgenerate

    logic [WIDTH-1:0] last_tb_q;
    logic             seen_q;
    logic             pin_prev_q;
    logic [3:0]       pre_q;
    logic [9:0]       duty_q;
    logic             hit;
    logic             fall;
    logic             rise;
    logic             is_cmp;
    logic             cap_now;
    logic             cap_q;
    logic             match_q;
    logic             special_q;

    // Event flops gathered into the output struct
    assign evt_q = '{match: match_q, special: special_q, capture: cap_q};

    // Capture condition for the selected edge mode
    always_comb
    begin
        unique case (ctrl.mode_select)
            CMU_CAP_FALL: cap_now = fall;
            CMU_CAP_RISE: cap_now = rise;
            CMU_CAP_4:    cap_now = rise && pre_q[1:0] == 2'h3;
            CMU_CAP_16:   cap_now = rise && pre_q == 4'hF;
            default:      cap_now = 1'b0;
        endcase
    end

    assign is_cmp = ctrl.mode_select[3:2] == 2'b10 ||
                    ctrl.mode_select == CMU_TOGGLE;
    // Match only once per equal count, not every clock
    assign hit = is_cmp && time_base == match_value &&
                 !(seen_q && last_tb_q == time_base);
    assign fall = pin_prev_q && !pin_in;
    assign rise = !pin_prev_q && pin_in;

    // Time base history for single match detection
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            last_tb_q <= '0;
            seen_q    <= 1'b0;
        end
        else if (ce)
        begin
            last_tb_q <= time_base;
            seen_q    <= time_base == match_value;
        end
    end

    // Capture prescaler, cleared when off or not capturing
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pre_q <= 4'h0;
        else if (ce)
        begin
            if (ctrl.mode_select[3:2] != 2'b01)
                pre_q <= 4'h0;
            else if (rise)
                pre_q <= pre_q + 4'h1;
        end
    end

    // Pin history and capture
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pin_prev_q <= 1'b0;
            capt_q     <= '0;
            cap_q      <= 1'b0;
        end
        else if (ce)
        begin
            pin_prev_q <= pin_in;
            cap_q      <= cap_now;
            // Value stands together with the capture strobe
            if (cap_now)
                capt_q <= time_base;
        end
    end

    // Compare events
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            match_q   <= 1'b0;
            special_q <= 1'b0;
        end
        else if (ce)
        begin
            match_q   <= hit;
            special_q <= hit && ctrl.mode_select == CMU_SPECIAL;
        end
    end

    // Output latch: init on entry to off, set-high or set-low, act on match, pwm
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pin_q  <= 1'b0;
            duty_q <= '0;
        end
        else if (ce)
        begin
            if (ctrl_wr && ctrl.mode_select == CMU_OFF)
                pin_q <= 1'b0;
            else if (ctrl_wr && ctrl.mode_select == CMU_SET_HI)
                pin_q <= 1'b0;
            else if (ctrl_wr && ctrl.mode_select == CMU_SET_LO)
                pin_q <= 1'b1;
            else if (ctrl.mode_select[3:2] == 2'b11)
            begin
                // Duty latched at period end, up to 10 bits
                if (pwm_period)
                begin
                    duty_q <= {match_value[7:0], ctrl.duty_low_bits};
                    pin_q  <= {match_value[7:0],
                               ctrl.duty_low_bits} != 10'h000;
                end
                else if ({pwm_base, pwm_frac} == duty_q)
                    pin_q <= 1'b0;
            end
            else if (hit)
            begin
                unique case (ctrl.mode_select)
                    CMU_TOGGLE: pin_q <= ~pin_q;
                    CMU_SET_HI: pin_q <= 1'b1;
                    CMU_SET_LO: pin_q <= 1'b0;
                    default:    pin_q <= pin_q;
                endcase
            end
        end
    end
endmodule

// *** cmu_top_checker.sv ***
module cmu_top_checker
    import cmu_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       ce,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata_q,
    input wire logic       port_g_line3_q,
    input wire logic       port_g_line4_q,
    input wire logic       unit4_open_drain_q,
    input wire logic       special_event_q,
    input wire logic       irq_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mask_q;
    cmu_mode_t  u4m_q;
    cmu_mode_t  u5m_q;
    logic       share_q;

    // Shadow of mask, modes and share bit
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mask_q  <= 8'h00;
            u4m_q   <= CMU_OFF;
            u5m_q   <= CMU_OFF;
            share_q <= 1'b0;
        end
        else if (wr && ce)
        begin
            if (addr == 8'h0E)
                mask_q <= wdata;
            if (addr == 8'h0A)
                u4m_q <= cmu_mode_t'(wdata[3:0]);
            if (addr == 8'h0B)
                u5m_q <= cmu_mode_t'(wdata[3:0]);
            if (addr == 8'h0C)
                share_q <= wdata[4];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Write to one register index
    sequence s_wr(a);
        wr && ce && addr == a;
    endsequence

    AST_RDATA_IDLE: assert property (
        !$past(rd && ce) |-> rdata_q == 8'h00)
        else $error("read data outside read cycle");
    AST_ZERO_U4: assert property (
        s_wr(8'h0A) ##0 wdata == 8'h00 |-> ##3 !port_g_line3_q)
        else $error("unit4 latch not low after off");
    AST_INIT_LOW: assert property (
        s_wr(8'h0A) ##0 wdata[3:0] == CMU_SET_HI |-> ##3 !port_g_line3_q)
        else $error("set-high entry not low");
    AST_INIT_HIGH: assert property (
        s_wr(8'h0B) ##0 wdata[3:0] == CMU_SET_LO |-> ##3 port_g_line4_q)
        else $error("set-low entry not high");
    AST_OD_SHARE: assert property (
        s_wr(8'h01) ##0 (share_q && wdata[3]) |-> ##[1:2] unit4_open_drain_q)
        else $error("open drain bit not written");
    AST_IRQ_MASKED: assert property (
        (mask_q == 8'h00) [*3] |-> !irq_q)
        else $error("interrupt while masked");
    AST_SWIRQ_PIN: assert property (
        (u4m_q == CMU_SW_IRQ) [*4] |-> $stable(port_g_line3_q))
        else $error("pin moved in interrupt-only mode");
    AST_SPECIAL_PULSE: assert property (
        special_event_q |=> !special_event_q)
        else $error("special event longer than one cycle");
    AST_SPECIAL_MODE: assert property (
        special_event_q |-> u4m_q == CMU_SPECIAL || u5m_q == CMU_SPECIAL)
        else $error("special event outside its mode");
endmodule

// *** cmu_far_end.sv ***
module cmu_far_end
(
    input  wire logic clk,
    output logic      line3_in,
    output logic      line4_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Lines idle low between edge trains
    initial
    begin
        line3_in = 1'b0;
        line4_in = 1'b0;
    end

    // Train of n pulses, four cycles high, five low between pulses
    task automatic pulse(input int lane, input int n);
        repeat (n)
        begin
            @(posedge clk);
            if (lane == 0)
                line3_in <= 1'b1;
            else
                line4_in <= 1'b1;
            repeat (4) @(posedge clk);
            line3_in <= 1'b0;
            line4_in <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule

// *** cmu_top_bench.sv ***
module cmu_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import cmu_pkg::*;
    logic        clk, reset, wr, rd, l3, l4, p3, p4, od4, od5, sev, irq;
    logic        ce;
    logic [7:0]  addr, wdata, r;
    logic [7:0]  rdata_q;
    logic [15:0] v;
    logic [31:0] seed = 32'hE968B088;
    int          bad_count, comparisons, sev_n;
    cmu_mode_t   modes[5] = '{CMU_TOGGLE, CMU_SET_HI, CMU_SET_LO,
                              CMU_SW_IRQ, CMU_SPECIAL};

    cmu_top uut (.clk, .reset, .ce, .addr, .wdata, .wr, .rd,
        .pwm_base(8'h00), .pwm_frac(2'h0), .pwm_period(1'b0),
        .port_g_line3_in(l3), .port_g_line4_in(l4), .rdata_q,
        .port_g_line3_q(p3), .port_g_line4_q(p4),
        .unit4_open_drain_q(od4), .unit5_open_drain_q(od5),
        .special_event_q(sev), .irq_q(irq));
    cmu_far_end far (.clk, .line3_in(l3), .line4_in(l4));

    // Clock, 5 ns period
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Count special event pulses
    always @(posedge clk)
        if (sev === 1'b1)
            sev_n++;

    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction

    // Expected pin after k matches
    function automatic logic pin_exp(cmu_mode_t m, int k);
        case (m)
            CMU_TOGGLE: return k[0];
            CMU_SET_HI: return k > 0;
            CMU_SET_LO: return k == 0;
            default:    return 1'b0;
        endcase
    endfunction

    function automatic logic pin(int u);
        return u ? p4 : p3;
    endfunction

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata_q;
    endtask

    task automatic chk(input string n, input logic [15:0] e, s);
        comparisons++;
        if (s !== e)
        begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask

    // Compare run: off, arm, then two matches
    task automatic run(input int u, input cmu_mode_t m);
        logic [7:0] tb, cb;
        tb = u ? 8'h03 : 8'h00;
        cb = 8'h0A + u[7:0];
        v = rnd();
        v[8] = 1'b1;
        wreg(cb, 8'h00);
        wait_n(2);
        chk("pin_off", 1'b0, pin(u));
        wreg(tb + 8'h01, 8'h00);
        wreg(8'h06 + u[7:0] * 2, v[7:0]);
        wreg(8'h07 + u[7:0] * 2, v[15:8]);
        wreg(8'h0D, 8'h03);
        wreg(8'h0E, m == CMU_SW_IRQ ? 8'h03 : 8'h00);
        sev_n = 0;
        wreg(cb, {4'h0, m});
        for (int k = 0; k < 3; k++)
        begin
            if (k > 0)
            begin
                wreg(tb + 8'h01, 8'h00);
                wreg(tb, v[7:0]);
                wreg(tb + 8'h01, v[15:8]);
            end
            wait_n(12);
            chk("pin", pin_exp(m, k), pin(u));
            chk("irq", m == CMU_SW_IRQ && k > 0, irq);
            chk("special", 16'(m == CMU_SPECIAL ? k : 0), 16'(sev_n));
            rreg(8'h0D, r);
            chk("flag", k > 0, r[u]);
            wreg(8'h0D, 8'h03);
        end
        wreg(cb, 8'h00);
    endtask

    // Capture after n edges
    task automatic cap(input int u, input cmu_mode_t m, input int n);
        logic [7:0] hi;
        v = rnd();
        wreg(8'h0A + u[7:0], 8'h00);
        wreg(8'h0A + u[7:0], {4'h0, m});
        wreg(u ? 8'h03 : 8'h00, v[7:0]);
        wreg(u ? 8'h04 : 8'h01, v[15:8]);
        wreg(8'h0D, 8'h03);
        far.pulse(u, n - 1);
        rreg(8'h0D, r);
        chk("early", 1'b0, r[u]);
        far.pulse(u, 1);
        rreg(8'h0D, r);
        chk("capt_flag", 1'b1, r[u]);
        rreg(8'h07 + u[7:0] * 2, hi);
        rreg(8'h06 + u[7:0] * 2, r);
        chk("capt_val", v, {hi, r});
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #100000;
        bad_count++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        {reset, ce, wr, rd, addr, wdata} = {2'b11, 18'h0};
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        v = rnd();
        wreg(8'h10, v[7:0]);
        for (int a = 0; a < 17; a++)
        begin
            rreg(a[7:0], r);
            chk("reset", a > 5 && a < 10 ? 8'hFF : 8'h00, r);
        end
        // Clock enable low: a write must not land
        ce <= 1'b0;
        wreg(8'h0E, 8'h03);
        ce <= 1'b1;
        rreg(8'h0E, r);
        chk("ce_hold", 8'h00, r);
        wreg(8'h01, 8'h5A);
        wreg(8'h0C, 8'h10);
        wreg(8'h01, 8'h18);
        wait_n(2);
        chk("od", 2'h3, {od5, od4});
        rreg(8'h01, r);
        chk("od_rd", 8'h18, r);
        wreg(8'h0C, 8'h00);
        rreg(8'h01, r);
        chk("t1h", 8'h5A, r);
        wreg(8'h02, 8'h00);
        wreg(8'h05, 8'h40);
        for (int u = 0; u < 2; u++)
            foreach (modes[i])
                run(u, modes[i]);
        cap(0, CMU_CAP_FALL, 1);
        cap(1, CMU_CAP_RISE, 1);
        cap(0, CMU_CAP_4, 4);
        cap(1, CMU_CAP_16, 16);
        tally_and_finish();
    end
endmodule

bind cmu_top cmu_top_checker chk_i (.clk, .reset, .ce, .addr, .wdata,
    .wr, .rd, .rdata_q, .port_g_line3_q, .port_g_line4_q,
    .unit4_open_drain_q, .special_event_q, .irq_q);
